//--- core/host_port_pkg.sv
// Constants for the host-facing control and status registers of the
// parallel host port. Assumes a single core clock and an async reset.
//
// Overview of operation
// R1: Control bit 0 gates receive requests; DMA direction.
// R2: Control bit 1 gates transmit requests; DMA direction. In DMA the code ignores bit 1; bit 0 alone picks direction.
// R3: Control bits 6:5 pick DMA off/24/16/8 bit.
// R4: Writing control bit 7 as one initialises DMA.
// R5: Host writes two flags; device side observes them.
// R6: Command bits 5:0 select one of 64 routines.
// R7: Command bit 7 raises command; zero means idle.
// R8: Status bit 0 shows receive data available.
// R9: Status bit 1 shows transmit space free.
// R10: Status bit 2 shows no host data held.
// R11: Status bits 4:3 show device-written flags, read-only.
// R12: Status bit 6 shows DMA mode active.
// R13: Status bit 7 mirrors host request line.
// R14: Status register resets to 06 hex.
// R15: Control register resets to 00 hex.
// R16: Vector register at offset 3, resets 0F.
// R17: Reserved bits read zero, writes ignored.
package host_port_pkg;

    // =========================================================
    // Register offsets on the host address pins
    // =========================================================
    localparam int          ADDR_W   = 3;
    localparam logic [2:0]  OFS_CTRL = 3'h0;
    localparam logic [2:0]  OFS_CMD  = 3'h1;
    localparam logic [2:0]  OFS_STAT = 3'h2;
    localparam logic [2:0]  OFS_VEC  = 3'h3;

    // =========================================================
    // Field positions
    // =========================================================
    localparam int CTRL_RX_EN  = 0;
    localparam int CTRL_TX_EN  = 1;
    localparam int CTRL_FLAG_A = 3;
    localparam int CTRL_FLAG_B = 4;
    localparam int CTRL_MODE_L = 5;
    localparam int CTRL_MODE_H = 6;
    localparam int CTRL_INIT   = 7;
    localparam int CMD_REQ     = 7;
    localparam int VEC_W       = 6;
    localparam int STAT_RXF    = 0;
    localparam int STAT_TXE    = 1;
    localparam int STAT_DRAIN  = 2;
    localparam int STAT_FLAG_A = 3;
    localparam int STAT_FLAG_B = 4;
    localparam int STAT_DMA    = 6;
    localparam int STAT_REQ    = 7;

    // =========================================================
    // Writable masks and reset values
    // =========================================================
    localparam logic [7:0] CTRL_WR_MASK = 8'h7B;
    localparam logic [7:0] CMD_WR_MASK  = 8'hBF;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] CMD_RESET    = 8'h17;
    localparam logic [7:0] STAT_RESET   = 8'h06;
    localparam logic [7:0] VEC_RESET    = 8'h0F;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // =========================================================
    // Transfer mode codes
    // =========================================================
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_DMA24  = 2'h1;
    localparam logic [1:0] MODE_DMA16  = 2'h2;
    localparam logic [1:0] MODE_DMA8   = 2'h3;

    // Depth of the command hand-off buffer
    localparam logic [1:0] BUF_DEPTH   = 2'h2;

endpackage

//--- core/pair_buffer.sv
// Two-entry valid/ready buffer for words handed to the core side.
// Assumes both neighbours obey valid/ready on core_clk.
module pair_buffer
    import host_port_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    // =========================================================
    // State: head slot feeds the output straight from a flop
    // =========================================================
    typedef struct packed {
        logic [WIDTH-1:0] head;   // Oldest word
        logic [WIDTH-1:0] tail;   // Second word
        logic [1:0]       count;  // Words held
    } buf_state_s;

    buf_state_s q;
    buf_state_s next_q;
    logic       push;
    logic       pop;

    assign in_ready  = (q.count != BUF_DEPTH);
    assign out_valid = (q.count != 2'h0);
    assign out_data  = q.head;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Shift on pop so the output never needs a read mux
    always_comb begin
        next_q = q;
        case ({push, pop})
            2'b10: begin
                if (q.count == 2'h0) begin
                    next_q.head = in_data;
                end else begin
                    next_q.tail = in_data;
                end
                next_q.count = q.count + 2'h1;
            end
            2'b01: begin
                next_q.head  = q.tail;
                next_q.count = q.count - 2'h1;
            end
            2'b11: begin
                // Full case cannot push, so count is one here
                next_q.head = in_data;
            end
            default: begin
                next_q = q;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_buf_keeps_word: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer dropped or changed a stalled word");
    chk_buf_fill_two: assert property (q.count == 2'h2 && !out_ready |=> q.count == 2'h2)
        else $error("full stalled buffer changed its fill");
    cov_buf_full: cover property (q.count == 2'h2);

endmodule

//--- core/host_port_control_status.sv
// Host-facing control, command, status and vector registers of the
// parallel host port. Assumes host strobes are synchronous to core_clk
// and that the core side supplies buffer state and its own two flags.
module host_port_control_status
    import host_port_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Host register pins
    input  wire logic              host_cs,
    input  wire logic              host_rd,
    input  wire logic              host_wr,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic [7:0]        host_data_in,
    output logic [7:0]             host_data_out,
    output logic                   host_data_oe,
    output logic                   request_line_state,
    // Core-side state shown to the host
    input  wire logic              receive_full,
    input  wire logic              transmit_empty,
    input  wire logic              core_rx_empty,
    input  wire logic              dsp_written_flag_a,
    input  wire logic              dsp_written_flag_b,
    // Control handed to the core side
    output logic                   receive_request_enable,
    output logic                   transmit_request_enable,
    output logic                   host_written_flag_a,
    output logic                   host_written_flag_b,
    output logic                   transfer_mode_bit_low,
    output logic                   transfer_mode_bit_high,
    output logic                   dma_init,
    output logic [7:0]             acknowledge_vector,
    // Host command toward the core
    output logic                   command_valid,
    input  wire logic              command_ready,
    output logic [VEC_W-1:0]       command_vector_number
);

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [7:0] ctrl;     // Interrupt control
        logic [7:0] cmd;      // Command vector
        logic [7:0] status;   // Interrupt status snapshot
        logic [7:0] vec;      // Acknowledge vector
        logic [7:0] rdata;    // Read data toward host
        logic       oe;       // Drive host data pins
        logic       init;     // DMA initialise pulse
        logic       req;      // Host request line
    } hp_state_s;

    hp_state_s        q;
    hp_state_s        next_q;
    logic             wr_hit;     // Host write this cycle
    logic             rd_hit;     // Host read this cycle
    logic             dma_on;     // Any DMA width chosen
    logic             drained;    // No host data held anywhere
    logic             next_req;   // Request line next value
    logic             buf_ready;  // Buffer can take a command
    logic             cmd_push;   // Command handed to buffer

    assign wr_hit   = host_cs && host_wr;
    assign rd_hit   = host_cs && host_rd;
    assign dma_on   = (q.ctrl[CTRL_MODE_H:CTRL_MODE_L] != MODE_OFF);      // see R12
    assign drained  = transmit_empty && core_rx_empty;                   // see R10
    assign cmd_push = q.cmd[CMD_REQ] && buf_ready;                       // see R7

    // =========================================================
    // Request line
    // =========================================================
    // DMA off: each enable gates its own buffer event. DMA on: the
    // receive enable alone picks direction, the transmit enable being
    // its complement in legal use.
    always_comb begin
        if (!dma_on) begin
            next_req = (q.ctrl[CTRL_RX_EN] && receive_full)                // see R1
                    || (q.ctrl[CTRL_TX_EN] && transmit_empty);             // see R2
        end else if (q.ctrl[CTRL_RX_EN]) begin
            next_req = receive_full;                                     // see R1
        end else begin
            next_req = transmit_empty;                                   // see R2
        end
    end

    // =========================================================
    // Register next state
    // =========================================================
    always_comb begin
        next_q      = q;
        next_q.init = 1'b0;
        next_q.oe   = 1'b0;
        next_q.req  = next_req;
        // Status snapshot built with the same request value so that
        // bit 7 never disagrees with the pin
        next_q.status = '0;                                              // see R17
        next_q.status[STAT_RXF]    = receive_full;                       // see R8
        next_q.status[STAT_TXE]    = transmit_empty;                     // see R9
        next_q.status[STAT_DRAIN]  = drained;                            // see R10
        next_q.status[STAT_FLAG_A] = dsp_written_flag_a;                 // see R11
        next_q.status[STAT_FLAG_B] = dsp_written_flag_b;                 // see R11
        next_q.status[STAT_DMA]    = dma_on;                             // see R12
        next_q.status[STAT_REQ]    = next_req;                           // see R13
        // Command leaves for the core; a host write below wins
        if (cmd_push) begin
            next_q.cmd[CMD_REQ] = 1'b0;                                  // see R7
        end
        // Host writes
        if (wr_hit) begin
            case (host_addr)
                OFS_CTRL: begin
                    next_q.ctrl = host_data_in & CTRL_WR_MASK;           // see R3, R17
                    next_q.init = host_data_in[CTRL_INIT];               // see R4
                end
                OFS_CMD: begin
                    next_q.cmd = host_data_in & CMD_WR_MASK;             // see R6, R17
                end
                OFS_VEC: begin
                    next_q.vec = host_data_in;                           // see R16
                end
                default: begin
                    // Status is driven by hardware; other offsets unmapped
                    next_q.vec = q.vec;
                end
            endcase
        end
        // Host reads, answered one cycle later
        if (rd_hit) begin
            next_q.oe = 1'b1;
            case (host_addr)
                OFS_CTRL: next_q.rdata = q.ctrl;                         // see R17
                OFS_CMD:  next_q.rdata = q.cmd;
                OFS_STAT: next_q.rdata = q.status;
                OFS_VEC:  next_q.rdata = q.vec;
                default:  next_q.rdata = READ_ZERO;
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.ctrl   <= CTRL_RESET;                                      // see R15
            q.cmd    <= CMD_RESET;
            q.status <= STAT_RESET;                                      // see R14
            q.vec    <= VEC_RESET;                                       // see R16
        end else begin
            q <= next_q;
        end
    end

    // =========================================================
    // Command hand-off buffer
    // =========================================================
    // With a stalled core, a full buffer keeps the command bit set, so the host sees it
    // still pending rather than losing the request.
    pair_buffer #(
        .WIDTH (VEC_W)
    ) u_cmd_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (q.cmd[CMD_REQ]),
        .in_ready  (buf_ready),
        .in_data   (q.cmd[VEC_W-1:0]),                                   // see R6
        .out_valid (command_valid),
        .out_ready (command_ready),
        .out_data  (command_vector_number)
    );

    // =========================================================
    // Outputs
    // =========================================================
    assign host_data_out           = q.rdata;
    assign host_data_oe            = q.oe;
    assign request_line_state      = q.req;
    assign receive_request_enable  = q.ctrl[CTRL_RX_EN];
    assign transmit_request_enable = q.ctrl[CTRL_TX_EN];
    assign host_written_flag_a     = q.ctrl[CTRL_FLAG_A];                // see R5
    assign host_written_flag_b     = q.ctrl[CTRL_FLAG_B];                // see R5
    assign transfer_mode_bit_low   = q.ctrl[CTRL_MODE_L];                // see R3
    assign transfer_mode_bit_high  = q.ctrl[CTRL_MODE_H];                // see R3
    assign dma_init                = q.init;                             // see R4
    assign acknowledge_vector      = q.vec;

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_init_one_pulse: assert property (                                  // see R4
        wr_hit && host_addr == OFS_CTRL && host_data_in[CTRL_INIT] |=> dma_init ##1 !dma_init)
        else $error("initialise write did not give one pulse");

    chk_init_zero_quiet: assert property (                                 // see R4
        wr_hit && host_addr == OFS_CTRL && !host_data_in[CTRL_INIT] |=> !dma_init)
        else $error("initialise pulse without a one written");

    chk_mode_field_out: assert property (                                  // see R3
        wr_hit && host_addr == OFS_CTRL |=>
        {transfer_mode_bit_high, transfer_mode_bit_low} == $past(host_data_in[6:5]))
        else $error("mode field not taken from write");

    chk_rx_request_on: assert property (                                   // see R1
        !dma_on && q.ctrl[CTRL_RX_EN] && receive_full |=> request_line_state)
        else $error("receive request not raised");

    chk_tx_request_on: assert property (                                   // see R2
        !dma_on && q.ctrl[CTRL_TX_EN] && transmit_empty |=> request_line_state)
        else $error("transmit request not raised");

    chk_request_gated_off: assert property (                               // see R1
        !dma_on && q.ctrl[1:0] == 2'b00 |=> !request_line_state)
        else $error("request raised with both enables clear");

    chk_request_mirror: assert property (                                  // see R13
        rd_hit && host_addr == OFS_STAT |=> host_data_out[STAT_REQ] == $past(request_line_state))
        else $error("status request bit differs from pin");

    chk_dma_status_bit: assert property (                                  // see R12
        ##1 q.status[STAT_DMA] == ($past(q.ctrl[6:5]) != MODE_OFF))
        else $error("DMA status bit wrong");

    chk_buffer_status_bits: assert property (                              // see R8
        ##1 q.status[2:0] == $past({drained, transmit_empty, receive_full}))
        else $error("buffer status bits wrong");

    chk_core_flags_shown: assert property (                                // see R11
        ##1 q.status[4:3] == $past({dsp_written_flag_b, dsp_written_flag_a}))
        else $error("core flags not shown in status");

    chk_cmd_waits_buffer: assert property (                                // see R7
        q.cmd[CMD_REQ] && !buf_ready && !wr_hit |=> q.cmd[CMD_REQ])
        else $error("pending command lost while buffer full");

    chk_cmd_vector_sent: assert property (                                 // see R6
        cmd_push && !command_valid |=> command_valid && command_vector_number == $past(q.cmd[5:0]))
        else $error("command vector not handed on");

    chk_reserved_reads: assert property (                                  // see R17
        rd_hit && host_addr == OFS_CTRL |=> host_data_oe && host_data_out[CTRL_INIT] == 1'b0)
        else $error("reserved control bit read as one");

    chk_vector_write: assert property (                                    // see R16
        wr_hit && host_addr == OFS_VEC |=> acknowledge_vector == $past(host_data_in))
        else $error("vector register not written");

    cov_command_sent: cover property (cmd_push ##[1:4] command_valid && command_ready);
    cov_dma_request: cover property (dma_on && request_line_state);
    cov_status_read: cover property (rd_hit && host_addr == OFS_STAT ##1 host_data_oe);

endmodule

//--- tb/host_bus_model.sv
// Host processor model: runs one register cycle on the host pins per request.
// Assumes the bench holds go until done and that the port answers every read.
module host_bus_model
    import host_port_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              go,
    input  wire logic              op_wr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              host_data_oe,
    input  wire logic [7:0]        host_data_out,
    output logic                   host_cs,
    output logic                   host_rd,
    output logic                   host_wr,
    output logic [ADDR_W-1:0]      host_addr,
    output logic [7:0]             host_data_in,
    output logic                   done,
    output logic [7:0]             rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase;  // 0 idle, 1 strobe, 2 await read data

    // =========================================================
    // Bus cycle sequencer
    // =========================================================
    // Strobes last one edge; the done guard stops a restart on the hand-back edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase        <= 2'h0;
            host_cs      <= 1'b0;
            host_rd      <= 1'b0;
            host_wr      <= 1'b0;
            host_addr    <= '0;
            host_data_in <= 8'h00;
            done         <= 1'b0;
            rdata        <= 8'h00;
        end else begin
            done    <= 1'b0;
            host_cs <= 1'b0;
            host_rd <= 1'b0;
            host_wr <= 1'b0;
            if (phase == 2'h0 && go && !done) begin
                // Write data goes out as given, reserved bits included; the port masks them
                host_cs      <= 1'b1;
                host_rd      <= !op_wr;
                host_wr      <= op_wr;
                host_addr    <= addr;
                host_data_in <= wdata;
                phase        <= 2'h1;
            end else if (phase == 2'h1) begin
                // Released data lines show no stale value
                host_data_in <= ~host_data_in;
                done         <= op_wr;
                phase        <= op_wr ? 2'h0 : 2'h2;
            end else if (phase == 2'h2 && host_data_oe) begin
                rdata <= host_data_out;
                done  <= 1'b1;
                phase <= 2'h0;
            end
        end
    end
endmodule

//--- tb/host_port_control_status_tb_top.sv
// Self-checking bench for the host control and status registers.
// Assumes the host model drives the pins; the bench plays the core side.
module host_port_control_status_tb_top
    import host_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk, rst_n, go, op_wr, done;
    logic [ADDR_W-1:0] addr, host_addr;
    logic [7:0]        wdata, rdata, host_data_in, host_data_out, acknowledge_vector, c;
    logic              host_cs, host_rd, host_wr, host_data_oe, request_line_state;
    logic              receive_full, transmit_empty, core_rx_empty, dsp_written_flag_a, dsp_written_flag_b;
    logic              receive_request_enable, transmit_request_enable, host_written_flag_a;
    logic              host_written_flag_b, transfer_mode_bit_low, transfer_mode_bit_high, dma_init;
    logic              command_valid, command_ready, init_seen, q;
    logic [VEC_W-1:0]  command_vector_number;
    logic [5:0]        exp_v [3];
    int                num_errors = 0;
    int                n_tests = 0;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    host_port_control_status DUT (.core_clk(core_clk), .rst_n(rst_n), .host_cs(host_cs), .host_rd(host_rd),
        .host_wr(host_wr), .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .request_line_state(request_line_state), .receive_full(receive_full),
        .transmit_empty(transmit_empty), .core_rx_empty(core_rx_empty), .dsp_written_flag_a(dsp_written_flag_a),
        .dsp_written_flag_b(dsp_written_flag_b), .receive_request_enable(receive_request_enable),
        .transmit_request_enable(transmit_request_enable), .host_written_flag_a(host_written_flag_a),
        .host_written_flag_b(host_written_flag_b), .transfer_mode_bit_low(transfer_mode_bit_low),
        .transfer_mode_bit_high(transfer_mode_bit_high), .dma_init(dma_init),
        .acknowledge_vector(acknowledge_vector), .command_valid(command_valid), .command_ready(command_ready),
        .command_vector_number(command_vector_number));

    host_bus_model host (.core_clk(core_clk), .rst_n(rst_n), .go(go), .op_wr(op_wr), .addr(addr),
        .wdata(wdata), .host_data_oe(host_data_oe), .host_data_out(host_data_out), .host_cs(host_cs),
        .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr), .host_data_in(host_data_in),
        .done(done), .rdata(rdata));

    // =========================================================
    // Shared tasks
    // =========================================================
    // Verdict and end of run, also reached from the watchdog
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One host cycle; entered at a clock edge, returns one edge after the edge done is seen
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        go    <= 1'b1;
        op_wr <= w;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        while (done !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        go        <= 1'b0;
        init_seen = dma_init;  // Init pulse stands in the cycle after the write edge
        if (done !== 1'b1) num_errors++;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdata, exp);
    endtask

    // =========================================================
    // Watchdog: the whole sequence needs well under 2000 cycles
    // =========================================================
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        core_clk = 1'b0; rst_n = 1'b0; go = 1'b0; op_wr = 1'b0; addr = '0; wdata = 8'h00;
        receive_full = 1'b0; transmit_empty = 1'b1; core_rx_empty = 1'b1;
        dsp_written_flag_a = 1'b0; dsp_written_flag_b = 1'b0; command_ready = 1'b0;
        exp_v = '{6'h05, 6'h3F, 6'h01};
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset state of outputs and registers
        chk(acknowledge_vector, VEC_RESET);
        chk({dma_init, receive_request_enable, transmit_request_enable, host_written_flag_a, host_written_flag_b,
             transfer_mode_bit_low, command_valid, transfer_mode_bit_high}, 8'h00);
        rd(OFS_CTRL, 8'h00);
        rd(OFS_CMD, 8'h17);
        rd(OFS_STAT, 8'h06);
        rd(OFS_VEC, 8'h0F);
        rd(3'h5, 8'h00);
        // All control bits: reserved and init read back zero, init pulses
        bus(1'b1, OFS_CTRL, 8'hFF);
        chk({7'h00, init_seen}, 8'h01);
        rd(OFS_CTRL, 8'h7B);
        chk({6'h00, host_written_flag_b, host_written_flag_a}, 8'h03);
        bus(1'b1, OFS_CTRL, 8'h80);
        chk({7'h00, init_seen}, 8'h01);
        rd(OFS_CTRL, 8'h00);
        // Every mode with each request enable and every receive_full/transmit_empty combination
        for (int m = 0; m < 4; m++) begin
            for (int e = 1; e < 3; e++) begin
                for (int k = 0; k < 4; k++) begin
                    c = {1'b0, m[1:0], 3'b000, e[1:0]};
                    bus(1'b1, OFS_CTRL, c);
                    chk({3'h0, init_seen, transfer_mode_bit_high, transfer_mode_bit_low, transmit_request_enable,
                         receive_request_enable}, {4'h0, m[1:0], e[1:0]});
                    receive_full       <= k[0];
                    transmit_empty     <= k[1];
                    core_rx_empty      <= e[0];
                    dsp_written_flag_a <= k[0];
                    dsp_written_flag_b <= ~k[1];
                    repeat (3) @(posedge core_clk);
                    // Direction from the receive enable in DMA, gating otherwise
                    q = (m == 0) ? ((e[0] & k[0]) | (e[1] & k[1])) : (e[0] ? k[0] : k[1]);
                    chk({7'h00, request_line_state}, {7'h00, q});
                    rd(OFS_STAT, {q, m != 0, 1'b0, ~k[1], k[0], k[1] & e[0], k[1], k[0]});
                end
            end
        end
        // Status and unmapped offsets refuse writes
        bus(1'b1, OFS_CTRL, 8'h00);
        receive_full   <= 1'b0;
        transmit_empty <= 1'b1;
        core_rx_empty  <= 1'b1;
        dsp_written_flag_b <= 1'b0;
        bus(1'b1, OFS_STAT, 8'hFF);
        rd(OFS_STAT, 8'h0E);
        bus(1'b1, OFS_VEC, 8'hA5);
        bus(1'b1, 3'h6, 8'hFF);
        rd(OFS_VEC, 8'hA5);
        chk(acknowledge_vector, 8'hA5);
        rd(3'h6, 8'h00);
        // Commands: two fill the buffer, the third stays pending while the core stalls
        bus(1'b1, OFS_CMD, 8'h85);
        bus(1'b1, OFS_CMD, 8'hFF);
        rd(OFS_CMD, 8'h3F);
        bus(1'b1, OFS_CMD, 8'h81);
        repeat (3) @(posedge core_clk);
        rd(OFS_CMD, 8'h81);
        for (int i = 0; i < 3; i++) begin
            for (int n = 0; n < 20 && command_valid !== 1'b1; n++) @(posedge core_clk);
            chk({command_valid, 1'b0, command_vector_number}, {2'h2, exp_v[i]});
            command_ready <= 1'b1;
            @(posedge core_clk);
            command_ready <= 1'b0;
            @(posedge core_clk);
        end
        repeat (2) @(posedge core_clk);
        chk({7'h00, command_valid}, 8'h00);
        rd(OFS_CMD, 8'h01);
        stop_test();
    end
endmodule
